// file: lld_pkg.sv
// Shared constants, command codes and carriers for the low-latency DDR memory device core.
// Assumes the command pins are sampled on clk, which is the memory's own command clock.
package lld_pkg;

  localparam int ADDR_PINS = 21;
  localparam int MUX_ADDR_PINS = 11;
  localparam int BANK_BITS = 3;
  localparam int MODE_BITS = 18;
  localparam int MODE_CFG_LSB = 0;
  localparam int MODE_BL_LSB = 3;
  localparam int MODE_MUX_BIT = 5;
  localparam int MODE_LOOP_BIT = 7;
  localparam int MODE_IMP_BIT = 8;
  localparam int MODE_TERM_BIT = 9;
  localparam logic [MODE_BITS-1:0] MODE_RESET = 18'h00000;

  localparam logic [2:0] CFG_CODE_2 = 3'h2;
  localparam logic [2:0] CFG_CODE_3 = 3'h3;
  localparam int RL_CFG1 = 4;
  localparam int RL_CFG2 = 6;
  localparam int RL_CFG3 = 8;
  localparam int RL_MAX = 8;

  localparam logic [1:0] BL_CODE_2 = 2'h0;
  localparam logic [1:0] BL_CODE_4 = 2'h1;
  localparam logic [1:0] BL_CODE_8 = 2'h2;

  localparam int LOOP_LOCK_CYCLES = 1024;
  localparam int MRSC_CYCLES = 6;
  localparam int CAL_PERIOD_CYCLES = 2048;
  localparam int INTERNAL_IMPEDANCE_OHM = 50;

  typedef enum logic [4:0] {
    LLD_CMD_NOP = 5'h01,
    LLD_CMD_MRS = 5'h02,
    LLD_CMD_READ = 5'h04,
    LLD_CMD_WRITE = 5'h08,
    LLD_CMD_REF = 5'h10
  } lld_cmd_e;

  typedef enum logic [1:0] {
    LLD_ST_FIRST = 2'h1,
    LLD_ST_SECOND = 2'h2
  } lld_state_e;

  typedef struct packed {
    logic csN;
    logic weN;
    logic refN;
    logic [BANK_BITS-1:0] bank;
    logic [ADDR_PINS-1:0] addr;
  } lld_pins_s;

  typedef struct packed {
    logic valid;
    logic [ADDR_PINS-1:0] addr;
    logic [2:0] pairs;
  } lld_req_s;

  typedef struct packed {
    logic [8:0] rise;
    logic [8:0] fall;
  } lld_ddr_s;

endpackage : lld_pkg

// file: lld_write_capture.sv
// Write data capture running on the write data clock.
// Assumes wrAddr and wrPairs stay stable from each wrToggle flip until the burst is taken.
`timescale 1ns/1ps
module lld_write_capture #(
  parameter int DQ_W = 9,
  parameter int ADDR_W = 8
) (
  input wire logic dataClk,
  input wire logic rst_n,
  input wire logic wrToggle,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [2:0] wrPairs,
  input wire logic [DQ_W-1:0] dqIn,
  input wire logic maskIn,
  output logic pairOpen,
  output logic [ADDR_W-1:0] pairAddr,
  output logic [DQ_W-1:0] riseData,
  output logic riseMask
);

  logic rstMeta;
  logic rstSync;
  logic togMeta;
  logic togSync;
  logic togSeen;
  logic [2:0] left;
  logic [ADDR_W-1:0] nextAddr;

  wire startBurst = togSync != togSeen;
  wire capturing = left != 3'h0;

  // Reset and toggle each pass two flops before use
  always_ff @(posedge dataClk)
  begin
    rstMeta <= rst_n;
    rstSync <= rstMeta;
    togMeta <= wrToggle;
    togSync <= togMeta;
  end

  // Rising edge element of each pair; falling half is taken by the memory port
  always_ff @(posedge dataClk)
  begin
    if (!rstSync)
    begin
      togSeen <= 1'b0;
      left <= 3'h0;
      nextAddr <= '0;
      pairOpen <= 1'b0;
      pairAddr <= '0;
      riseData <= '0;
      riseMask <= 1'b1;
    end
    else
    begin
      togSeen <= togSync;
      pairOpen <= capturing; // R14
      riseData <= dqIn; // R14
      riseMask <= maskIn;
      pairAddr <= nextAddr;
      if (startBurst)
      begin
        left <= wrPairs;
        nextAddr <= wrAddr;
      end
      else if (capturing)
      begin
        left <= left - 3'h1;
        nextAddr <= nextAddr + ADDR_W'(2);
      end
    end
  end

endmodule : lld_write_capture

// file: lld_device_core.sv
// Command decode, mode register, burst engines and memory of the low-latency DDR device.
// Assumes commands and read data live on clk; write data and mask arrive on dataClk.
`timescale 1ns/1ps
// Summary of operation
// R1: Usable address bits shrink with burst length and data width.
// R2: Multiplexed mode latches address in two parts on consecutive rising edges.
// R3: Controller gives bank with command and first part; second part next edge.
// R4: Refresh takes only bank, no second part, so may come every cycle.
// R5: Multiplex mode bit set makes read, write and mode set two-edge commands.
// R6: Multiplexed burst of two loses bus efficiency from two address clocks.
// R7: Loop reset bit low disables delay loop; high enables it.
// R8: Controller waits 1024 cycles after enabling loop before reading.
// R9: On clock or supply change controller cycles loop bit low then high.
// R10: Impedance bit high makes device periodically recalibrate against external resistor.
// R11: Impedance bit low uses internal 50 ohm impedance, still recalibrated periodically.
// R12: Termination bit enables termination on data and mask inputs only.
// R13: Data termination drops while driving read data; mask always terminated.
// R14: Write data captured on both write clock edges, burst length elements.
// R15: Write latency is read latency plus one cycle.
// R16: Controller puts at least one idle command between write and read.
// R17: Elements with write mask high are discarded, memory unchanged.
// R18: Read data driven after read latency, aligned to read strobe clock.
// R19: Read valid flag rises ahead of first read data.
// R20: Read valid flag drops on last element; data outputs then released.
// R21: Read strobe runs continuously; back-to-back reads stream without gaps.
// R22: Controller may add idle cycles between read and following write.
// R23: Mode set stores address bits 0 to 17; recovery time before others.
// R24: Mode bits 3 and 4 select burst length of two, four or eight.
module lld_device_core #(
  parameter int DQ_W = 9,
  parameter int ADDR_W = 8,
  parameter int CAL_PERIOD = lld_pkg::CAL_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dataClk,
  input wire lld_pkg::lld_pins_s cmdPins,
  input wire logic [DQ_W-1:0] dqIn,
  input wire logic writeMask,
  output lld_pkg::lld_ddr_s dqOut,
  output logic dqOeN,
  output logic readValid,
  output logic readStrobe,
  output logic dqTermOn,
  output logic maskTermOn,
  output logic loopEnable,
  output logic loopLocked,
  output logic impedanceExternal,
  output logic calStrobe,
  output logic muxMode,
  output logic recoveryBusy
);

  localparam int MEM_DEPTH = 2 ** ADDR_W;
  localparam int PIPE_LEN = lld_pkg::RL_MAX;

  function automatic lld_pkg::lld_cmd_e decodeCmd(input lld_pkg::lld_pins_s p);
    lld_pkg::lld_cmd_e k;
    k = lld_pkg::LLD_CMD_NOP;
    if (!p.csN)
    begin
      case ({p.weN, p.refN})
        2'b00: k = lld_pkg::LLD_CMD_MRS;
        2'b11: k = lld_pkg::LLD_CMD_READ;
        2'b01: k = lld_pkg::LLD_CMD_WRITE;
        2'b10: k = lld_pkg::LLD_CMD_REF;
        default: k = lld_pkg::LLD_CMD_NOP;
      endcase
    end
    return k;
  endfunction : decodeCmd

  function automatic logic [2:0] burstPairs(input logic [1:0] code);
    logic [2:0] n;
    n = 3'h1;
    case (code)
      lld_pkg::BL_CODE_4: n = 3'h2;
      lld_pkg::BL_CODE_8: n = 3'h4;
      default: n = 3'h1;
    endcase
    return n;
  endfunction : burstPairs

  function automatic logic [lld_pkg::ADDR_PINS-1:0] addrMask(input logic [1:0] code);
    int used;
    used = lld_pkg::ADDR_PINS - int'(code) - (DQ_W > 18 ? 2 : (DQ_W > 9 ? 1 : 0));
    if (used < 18)
    begin
      used = 18;
    end
    return lld_pkg::ADDR_PINS'((64'h1 << used) - 64'h1);
  endfunction : addrMask

  // Mode register and command state
  logic [lld_pkg::MODE_BITS-1:0] modeReg;
  lld_pkg::lld_state_e state;
  lld_pkg::lld_state_e next_state;
  lld_pkg::lld_cmd_e heldKind;
  logic [lld_pkg::MUX_ADDR_PINS-1:0] heldPart;
  logic [7:0] mrsWait;
  logic [10:0] lockCnt;
  logic [15:0] calCnt;

  // Read and write pipelines
  lld_pkg::lld_req_s rdPipe [0:PIPE_LEN-1];
  lld_pkg::lld_req_s wrPipe [0:PIPE_LEN-1];
  logic [2:0] rdLeft;
  logic [ADDR_W-1:0] rdAddr;
  logic wrToggle;
  logic [ADDR_W-1:0] wrAddr;
  logic [2:0] wrPairs;

  // Storage: write port on dataClk, read port on clk
  logic [DQ_W-1:0] mem [0:MEM_DEPTH-1];
  logic pairOpen;
  logic [ADDR_W-1:0] pairAddr;
  logic [DQ_W-1:0] riseData;
  logic riseMask;

  wire lld_pkg::lld_cmd_e pinKind = decodeCmd(cmdPins);
  wire [2:0] cfgCode = modeReg[lld_pkg::MODE_CFG_LSB +: 3];
  wire [1:0] blCode = modeReg[lld_pkg::MODE_BL_LSB +: 2];
  wire muxBit = modeReg[lld_pkg::MODE_MUX_BIT];
  wire loopBit = modeReg[lld_pkg::MODE_LOOP_BIT];
  wire impBit = modeReg[lld_pkg::MODE_IMP_BIT];
  wire termBit = modeReg[lld_pkg::MODE_TERM_BIT];
  wire recovering = mrsWait != 8'h00;
  wire [2:0] pairsNow = burstPairs(blCode); // R24
  wire [3:0] rlNow = (cfgCode == lld_pkg::CFG_CODE_2) ? 4'(lld_pkg::RL_CFG2) :
                     (cfgCode >= lld_pkg::CFG_CODE_3) ? 4'(lld_pkg::RL_CFG3) :
                     4'(lld_pkg::RL_CFG1);
  wire [3:0] rdSlot = rlNow - 4'h2;
  wire [3:0] wrSlot = rlNow - 4'h1; // R15

  // Two-part address only for read, write and mode set
  wire twoPartKind = (pinKind == lld_pkg::LLD_CMD_READ) || (pinKind == lld_pkg::LLD_CMD_WRITE) ||
                     (pinKind == lld_pkg::LLD_CMD_MRS); // R5
  wire firstEdge = state == lld_pkg::LLD_ST_FIRST;
  wire startTwoPart = muxBit && firstEdge && twoPartKind; // R2 R3
  wire secondEdge = state == lld_pkg::LLD_ST_SECOND;

  // Issued command: direct, or completed on the second edge
  wire lld_pkg::lld_cmd_e rawKind = secondEdge ? heldKind :
                                    (startTwoPart ? lld_pkg::LLD_CMD_NOP : pinKind); // R4
  wire [lld_pkg::ADDR_PINS-1:0] rawAddr = secondEdge ?
    {cmdPins.addr[lld_pkg::ADDR_PINS-lld_pkg::MUX_ADDR_PINS-1:0], heldPart} : cmdPins.addr; // R2
  wire allowed = !recovering || (rawKind == lld_pkg::LLD_CMD_MRS); // R23
  wire issueMrs = allowed && (rawKind == lld_pkg::LLD_CMD_MRS);
  wire issueRead = allowed && (rawKind == lld_pkg::LLD_CMD_READ);
  wire issueWrite = allowed && (rawKind == lld_pkg::LLD_CMD_WRITE);
  wire [lld_pkg::ADDR_PINS-1:0] usedAddr = rawAddr & addrMask(blCode); // R1
  wire lld_pkg::lld_req_s newReq = '{valid: 1'b1, addr: usedAddr, pairs: pairsNow};

  // Element addresses run consecutively from the command address
  wire [ADDR_W-1:0] reqIndex = rdPipe[0].addr[ADDR_W-1:0];
  wire rdLoad = rdPipe[0].valid;
  wire rdActive = rdLeft != 3'h0;
  wire [DQ_W-1:0] rdRise = mem[rdAddr];
  wire [DQ_W-1:0] rdFall = mem[rdAddr + ADDR_W'(1)];

  always_comb
  begin
    next_state = state;
    case (state)
      lld_pkg::LLD_ST_FIRST:
      begin
        if (startTwoPart)
        begin
          next_state = lld_pkg::LLD_ST_SECOND;
        end
      end
      lld_pkg::LLD_ST_SECOND: next_state = lld_pkg::LLD_ST_FIRST; // R6
      default: next_state = lld_pkg::LLD_ST_FIRST;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= lld_pkg::LLD_ST_FIRST;
      heldKind <= lld_pkg::LLD_CMD_NOP;
      heldPart <= '0;
    end
    else
    begin
      state <= next_state;
      if (startTwoPart)
      begin
        heldKind <= pinKind;
        heldPart <= cmdPins.addr[lld_pkg::MUX_ADDR_PINS-1:0];
      end
    end
  end

  // Mode register and recovery timer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      modeReg <= lld_pkg::MODE_RESET; // R7
      mrsWait <= 8'h00;
    end
    else if (issueMrs)
    begin
      modeReg <= rawAddr[lld_pkg::MODE_BITS-1:0]; // R23
      mrsWait <= 8'(lld_pkg::MRSC_CYCLES);
    end
    else if (recovering)
    begin
      mrsWait <= mrsWait - 8'h01;
    end
  end

  // Loop lock count restarts whenever the loop bit is dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n || !loopBit)
    begin
      lockCnt <= 11'h000; // R9
      loopLocked <= 1'b0;
    end
    else
    begin
      if (lockCnt != 11'(lld_pkg::LOOP_LOCK_CYCLES))
      begin
        lockCnt <= lockCnt + 11'h001;
      end
      loopLocked <= lockCnt == 11'(lld_pkg::LOOP_LOCK_CYCLES); // R8
    end
  end

  // Calibration runs in both impedance modes; only the reference differs
  always_ff @(posedge clk)
  begin
    if (!rst_n || calCnt == 16'(CAL_PERIOD - 1))
    begin
      calCnt <= 16'h0000;
    end
    else
    begin
      calCnt <= calCnt + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      calStrobe <= 1'b0;
      impedanceExternal <= 1'b0;
      loopEnable <= 1'b0;
      muxMode <= 1'b0;
      recoveryBusy <= 1'b0;
      readStrobe <= 1'b0;
      maskTermOn <= 1'b0;
    end
    else
    begin
      calStrobe <= calCnt == 16'(CAL_PERIOD - 1); // R10 R11
      impedanceExternal <= impBit; // R10 R11
      loopEnable <= loopBit; // R7
      muxMode <= muxBit; // R5
      recoveryBusy <= recovering;
      readStrobe <= !readStrobe; // R21
      maskTermOn <= termBit; // R12 R13
    end
  end

  // Latency pipelines: requests enter at the slot that sets their latency
  genvar gi;
  generate
    for (gi = 0; gi < PIPE_LEN; gi++)
    begin : g_pipe
      lld_pkg::lld_req_s rdNext;
      lld_pkg::lld_req_s wrNext;
      if (gi == PIPE_LEN - 1)
      begin : g_tail
        assign rdNext = '0;
        assign wrNext = '0;
      end
      else
      begin : g_body
        assign rdNext = rdPipe[gi+1];
        assign wrNext = wrPipe[gi+1];
      end
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          rdPipe[gi] <= '0;
          wrPipe[gi] <= '0;
        end
        else
        begin
          rdPipe[gi] <= (issueRead && rdSlot == 4'(gi)) ? newReq : rdNext; // R18
          wrPipe[gi] <= (issueWrite && wrSlot == 4'(gi)) ? newReq : wrNext; // R15
        end
      end
    end
  endgenerate

  // Read burst engine; a new load takes over at once so reads stream back to back
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdLeft <= 3'h0;
      rdAddr <= '0;
      readValid <= 1'b0;
      dqOeN <= 1'b1;
      dqTermOn <= 1'b0;
      dqOut <= '0;
    end
    else
    begin
      if (rdLoad)
      begin
        rdLeft <= rdPipe[0].pairs; // R21
        rdAddr <= reqIndex;
      end
      else if (rdActive)
      begin
        rdLeft <= rdLeft - 3'h1;
        rdAddr <= rdAddr + ADDR_W'(2);
      end
      readValid <= rdLoad || rdLeft > 3'h1; // R19 R20
      dqOeN <= !rdActive; // R18 R20
      dqTermOn <= termBit && !rdActive; // R12 R13
      if (rdActive)
      begin
        dqOut.rise <= 9'(rdRise); // R18
        dqOut.fall <= 9'(rdFall);
      end
    end
  end

  // Write hand-off: address held until the next write, event by toggle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wrToggle <= 1'b0;
      wrAddr <= '0;
      wrPairs <= 3'h0;
    end
    else if (wrPipe[0].valid)
    begin
      wrToggle <= !wrToggle;
      wrAddr <= wrPipe[0].addr[ADDR_W-1:0];
      wrPairs <= wrPipe[0].pairs;
    end
  end

  lld_write_capture #(
    .DQ_W(DQ_W),
    .ADDR_W(ADDR_W)
  ) u_capture (
    .dataClk(dataClk),
    .rst_n(rst_n),
    .wrToggle(wrToggle),
    .wrAddr(wrAddr),
    .wrPairs(wrPairs),
    .dqIn(dqIn),
    .maskIn(writeMask),
    .pairOpen(pairOpen),
    .pairAddr(pairAddr),
    .riseData(riseData),
    .riseMask(riseMask)
  );

  // Pair written on the falling edge, so no edge is needed after the burst
  always_ff @(negedge dataClk)
  begin
    if (pairOpen)
    begin
      if (!riseMask)
      begin
        mem[pairAddr] <= riseData; // R17
      end
      if (!writeMask)
      begin
        mem[pairAddr + ADDR_W'(1)] <= dqIn; // R14 R17
      end
    end
  end

endmodule : lld_device_core

// file: lld_checker.sv
// Port-level assertions for the device core.
// Assumes one command clock domain; attached by the bind at the foot.
`timescale 1ns/1ps
module lld_checker #(
  parameter int CAL_PERIOD = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dqOeN,
  input wire logic readValid,
  input wire logic readStrobe,
  input wire logic dqTermOn,
  input wire logic maskTermOn,
  input wire logic loopEnable,
  input wire logic loopLocked,
  input wire logic calStrobe,
  input wire logic recoveryBusy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [10:0] lockCnt;
  logic [15:0] calGap;
  // Saturates so a stuck lock flag cannot wrap back into range
  always_ff @(posedge clk)
  begin
    if (!rst_n || !loopEnable)
      lockCnt <= 11'h000;
    else if (lockCnt != 11'h7ff)
      lockCnt <= lockCnt + 11'h001;
  end
  // Long calibration periods would overflow a plain delay, so the gap is counted
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      calGap <= 16'h0000;
    else if (calStrobe)
      calGap <= 16'h0001;
    else if (calGap != 16'hffff)
      calGap <= calGap + 16'h0001;
  end
  chk_valid_lead: assert property ($rose(readValid) |=> !dqOeN)
    else $error("data did not follow valid");
  chk_oe_cause: assert property ($fell(dqOeN) |-> $past(readValid))
    else $error("data driven without valid");
  chk_valid_drop: assert property ($fell(readValid) |-> !dqOeN)
    else $error("valid fell off the last pair");
  chk_bus_release: assert property ($rose(dqOeN) |-> !$past(readValid))
    else $error("bus released while valid");
  chk_term_read: assert property (!dqOeN |-> !dqTermOn)
    else $error("termination on while driving");
  chk_mask_term: assert property (dqTermOn |-> maskTermOn)
    else $error("mask termination off");
  chk_strobe_run: assert property ($past(rst_n) |-> readStrobe != $past(readStrobe))
    else $error("read strobe stalled");
  chk_lock_early: assert property (loopLocked |-> lockCnt >= 11'h3fc)
    else $error("loop locked too early");
  chk_lock_late: assert property (loopEnable && lockCnt >= 11'h406 |-> loopLocked)
    else $error("loop lock missing");
  chk_cal_period: assert property (calStrobe |-> calGap == 16'(CAL_PERIOD))
    else $error("calibration period wrong");
  chk_cal_missing: assert property (calGap <= 16'(CAL_PERIOD))
    else $error("calibration strobe missing");
  chk_recovery_len: assert property ($rose(recoveryBusy) |->
    recoveryBusy [*4] ##[1:4] !recoveryBusy)
    else $error("recovery length wrong");
  cover property ($rose(loopLocked));
  cover property ($fell(dqOeN));
  cover property ($rose(recoveryBusy));
endmodule : lld_checker

bind lld_device_core lld_checker #(.CAL_PERIOD(CAL_PERIOD)) chk (.clk(clk), .rst_n(rst_n),
  .dqOeN(dqOeN), .readValid(readValid), .readStrobe(readStrobe), .dqTermOn(dqTermOn),
  .maskTermOn(maskTermOn), .loopEnable(loopEnable), .loopLocked(loopLocked),
  .calStrobe(calStrobe), .recoveryBusy(recoveryBusy));

// file: lld_ctrl_model.sv
// Behavioural memory controller driving command pins and write data.
// Assumes the bench calls its tasks; dataClk is made outside.
`timescale 1ns/1ps
module lld_ctrl_model (
  input wire logic clk,
  input wire logic dataClk,
  output lld_pkg::lld_pins_s pins,
  output logic [8:0] dq,
  output logic mask
);
  initial
  begin
    pins = '{csN: 1'b1, weN: 1'b1, refN: 1'b1, bank: 3'h0, addr: 21'h0};
    dq = 9'h000;
    mask = 1'b0;
  end
  // Idle pins show the inverse so a stale value cannot pass
  task automatic issue(input logic [1:0] kind, input logic [20:0] a, input logic two,
    input logic [20:0] a2);
    @(posedge clk);
    #1;
    pins = '{csN: 1'b0, weN: kind[1], refN: kind[0], bank: 3'h5, addr: a};
    // Refresh takes one edge only, so the next command may follow at once
    if (kind != 2'b10)
    begin
      @(posedge clk);
      #1;
      pins.csN = 1'b1;
      pins.addr = two ? a2 : ~a;
    end
  endtask : issue
  // Rise carries the even element, fall the odd one
  task automatic wdata(input logic [8:0] d0, input logic [8:0] d1, input logic m1);
    @(negedge dataClk);
    #1;
    dq = d0;
    mask = 1'b0;
    @(posedge dataClk);
    #1;
    dq = d1;
    mask = m1;
    @(negedge dataClk);
    #1;
    dq = ~d1;
    mask = ~m1;
  endtask : wdata
endmodule : lld_ctrl_model

// file: testbench.sv
// Self-checking bench for the device core.
// Assumes the controller model drives all command and write pins.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic dataClk = 1'b0;
  logic rst_n = 1'b0;
  lld_pkg::lld_pins_s cmdPins;
  logic [8:0] dqIn;
  logic writeMask;
  lld_pkg::lld_ddr_s dqOut;
  logic dqOeN, readValid, readStrobe, dqTermOn, maskTermOn, loopEnable;
  logic loopLocked, impedanceExternal, calStrobe, muxMode, recoveryBusy;
  lld_pkg::lld_ddr_s p2 = '{9'h1a5, 9'h05a};
  lld_pkg::lld_ddr_s p3 = '{9'h1ff, 9'h122};
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  // Offset start keeps the link clock out of phase with clk
  initial
  begin
    #7;
    forever #15 dataClk = ~dataClk;
  end
  lld_ctrl_model ctl (.clk(clk), .dataClk(dataClk), .pins(cmdPins), .dq(dqIn),
    .mask(writeMask));
  lld_device_core #(.DQ_W(9), .ADDR_W(8), .CAL_PERIOD(16)) dut (.clk(clk), .rst_n(rst_n),
    .dataClk(dataClk), .cmdPins(cmdPins), .dqIn(dqIn), .writeMask(writeMask), .dqOut(dqOut),
    .dqOeN(dqOeN), .readValid(readValid), .readStrobe(readStrobe), .dqTermOn(dqTermOn),
    .maskTermOn(maskTermOn), .loopEnable(loopEnable), .loopLocked(loopLocked),
    .impedanceExternal(impedanceExternal), .calStrobe(calStrobe), .muxMode(muxMode),
    .recoveryBusy(recoveryBusy));
  task automatic end_of_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_pair(input lld_pkg::lld_ddr_s got, input lld_pkg::lld_ddr_s exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pair
  task automatic mset(input logic [17:0] word);
    ctl.issue(2'b00, {3'h0, word}, 1'b0, 21'h0);
    repeat (8) @(posedge clk);
    #1;
  endtask : mset
  task automatic wr(input logic [20:0] a, input lld_pkg::lld_ddr_s d, input logic m1);
    ctl.issue(2'b01, a, 1'b0, 21'h0);
    repeat (4) @(posedge clk);
    // Toggle passes two flops and a detect edge before the capture edge
    repeat (3) @(posedge dataClk);
    ctl.wdata(d.rise, d.fall, m1);
    repeat (4) @(posedge clk);
  endtask : wr
  task automatic rd_chk(input logic [20:0] a, input logic two, input lld_pkg::lld_ddr_s exp);
    ctl.issue(2'b11, a, two, 21'h0);
    repeat (two ? 4 : 3) @(posedge clk);
    #1;
    chk_bit(readValid, 1'b1);
    @(posedge clk);
    #1;
    chk_pair(dqOut, exp);
    chk_bit(dqOeN, 1'b0);
    chk_bit(dqTermOn, 1'b0);
    chk_bit(readValid, 1'b0);
    @(posedge clk);
    #1;
    chk_bit(dqOeN, 1'b1);
    chk_bit(dqTermOn, 1'b1);
  endtask : rd_chk
  task automatic t_reset();
    chk_bit(dqOeN, 1'b1);
    chk_bit(loopEnable, 1'b0);
    chk_bit(muxMode, 1'b0);
    chk_bit(impedanceExternal, 1'b0);
    chk_bit(maskTermOn, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_write_read();
    mset(18'h00300);
    chk_bit(impedanceExternal, 1'b1);
    chk_bit(maskTermOn, 1'b1);
    chk_bit(dqTermOn, 1'b1);
    wr(21'h2, p2, 1'b0);
    wr(21'h4, '{9'h111, 9'h122}, 1'b0);
    wr(21'h4, '{9'h1ff, 9'h0ee}, 1'b1);
    rd_chk(21'h4, 1'b0, p3);
    rd_chk(21'h2, 1'b0, p2);
    $display("test write read done");
  endtask : t_write_read
  task automatic t_stream();
    // A read inside the recovery window must be ignored
    ctl.issue(2'b00, 21'h00308, 1'b0, 21'h0);
    ctl.issue(2'b11, 21'h2, 1'b0, 21'h0);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      #1;
      chk_bit(dqOeN, 1'b1);
      chk_bit(recoveryBusy, k < 4);
    end
    ctl.issue(2'b11, 21'h2, 1'b0, 21'h0);
    ctl.issue(2'b11, 21'h2, 1'b0, 21'h0);
    // First pair of the first read comes four edges after its command
    @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      #1;
      chk_bit(dqOeN, 1'b0);
      chk_pair(dqOut, k[0] ? p3 : p2);
    end
    $display("test stream done");
  endtask : t_stream
  task automatic t_loop();
    int calN;
    logic s;
    calN = 0;
    mset(18'h00380);
    chk_bit(loopEnable, 1'b1);
    chk_bit(loopLocked, 1'b0);
    // A window of 1024 cycles holds a whole number of calibration periods
    for (int k = 0; k < 1024; k++)
    begin
      @(posedge clk);
      #1;
      calN += int'(calStrobe);
    end
    repeat (6) @(posedge clk);
    #1;
    chk_bit(loopLocked, 1'b1);
    chk_bit(calN == 64, 1'b1);
    mset(18'h00300);
    chk_bit(loopEnable, 1'b0);
    chk_bit(loopLocked, 1'b0);
    s = readStrobe;
    @(posedge clk);
    #1;
    chk_bit(readStrobe, !s);
    $display("test loop done");
  endtask : t_loop
  task automatic t_mux();
    mset(18'h00320);
    chk_bit(muxMode, 1'b1);
    // A run of single-edge refreshes of any length leaves the read on the next edge
    ctl.issue(2'b10, 21'h0, 1'b0, 21'h0);
    ctl.issue(2'b10, 21'h0, 1'b0, 21'h0);
    ctl.issue(2'b10, 21'h0, 1'b0, 21'h0);
    rd_chk(21'h4, 1'b1, p3);
    $display("test mux done");
  endtask : t_mux
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_write_read();
    t_stream();
    t_loop();
    t_mux();
    end_of_test();
  end
endmodule : testbench
